/* rsq_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module rsq_sequencer
    import rsq_pkg::*;
(
    input  wire logic   core_clk_i,
    input  wire logic   resetn_i,
    input  wire logic   ext_reset_n_i,
    input  wire logic   low_voltage_detector_i,
    input  wire logic   power_good_i,
    input  wire logic   wdt_overflow_i,
    output var  logic   sys_reset_n_o,
    output var  logic   reg_init_o,
    output var  logic   osc_enable_o,
    output var  logic   core_clk_en_o,
    output var  logic   pc_start_o,
    output var  logic   reset_cause_hi_flag_o,
    output var  logic   reset_cause_lo_flag_o
);

    // ----------------------------------------------------------------
    // Input synchroniser.
    // ----------------------------------------------------------------
    rsq_sync_if sync_bus ();

    rsq_sync u_sync (
        .core_clk_i             (core_clk_i),
        .resetn_i               (resetn_i),
        .ext_reset_n_i          (ext_reset_n_i),
        .low_voltage_detector_i (low_voltage_detector_i),
        .power_good_i           (power_good_i),
        .sync                   (sync_bus)
    );

    // ----------------------------------------------------------------
    // Sequencer state.
    // ----------------------------------------------------------------
    rsq_state_t              state;
    rsq_state_t              next_state;
    logic [WARM_CNT_W-1:0]   warm_cnt;
    logic [WARM_CNT_W-1:0]   next_warm_cnt;
    logic [1:0]              cause;
    logic [1:0]              next_cause;

    logic pin_low;
    logic power_bad;
    logic wdt_hit;
    logic any_event;
    logic release_ok;

    // ----------------------------------------------------------------
    // Synchroniser settle time.
    // ----------------------------------------------------------------
    // The synchroniser is preloaded to a released pin and a good supply,
    // so for the first few edges after reset it shows those preloads and
    // not the real pins. A pin still held low at that moment must not let
    // the sequence move on to initialise, so release waits until the
    // preload has been flushed out of every stage and the filter.
    logic [2:0]              settle_cnt;
    logic [2:0]              next_settle_cnt;
    logic                    settled;

    // Counts up once after reset and then stands at its last value.
    always_comb begin
        next_settle_cnt = settle_cnt;
        if (settle_cnt != SETTLE_LAST) begin
            next_settle_cnt = settle_cnt + 3'h1;
        end
    end

    // Registers the settle count.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            settle_cnt <= SETTLE_ZERO;
        end else begin
            settle_cnt <= next_settle_cnt;
        end
    end

    // True once the filtered levels follow the real pins.
    assign settled = (settle_cnt == SETTLE_LAST); // see RULE_03

    // Reset sources, seen as levels except the watchdog pulse.
    always_comb begin
        pin_low    = !sync_bus.pin_high;                           // see RULE_02
        power_bad  = sync_bus.lvd_trip || !sync_bus.power_good;    // see RULE_05
        wdt_hit    = wdt_overflow_i && (state != ST_HOLD);         // see RULE_06
        any_event  = pin_low || power_bad || wdt_hit;
        // Leave reset only with the pin high and the supply in range.
        release_ok = sync_bus.pin_high && !power_bad && settled;   // see RULE_03
    end

    // Next state, warm-up count and cause.
    always_comb begin
        next_state    = state;
        next_warm_cnt = warm_cnt;
        next_cause    = cause;
        if (any_event) begin
            // Every source restarts the full sequence from the top.
            next_state    = ST_HOLD;                                // see RULE_08
            next_warm_cnt = WARM_ZERO;
            if (state != ST_HOLD || pin_low || power_bad) begin
                next_cause = rsq_pick_cause(pin_low, power_bad, 1'b0); // see RULE_09
            end
        end else begin
            case (state)
                ST_HOLD: begin
                    // A watchdog reset in a sagging supply waits here.
                    if (release_ok) begin                           // see RULE_07
                        next_state = ST_INIT;
                    end
                end
                ST_INIT: begin
                    next_state    = ST_WARM;                        // see RULE_04
                    next_warm_cnt = WARM_ZERO;
                end
                ST_WARM: begin
                    if (warm_cnt == WARM_LAST) begin
                        next_state = ST_RUN;
                    end else begin
                        next_warm_cnt = warm_cnt + 12'h001;
                    end
                end
                ST_RUN: begin
                    next_state = ST_RUN;
                end
                default: begin
                    next_state = ST_HOLD;
                end
            endcase
        end
    end

    // Registers of the sequencer.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            state    <= ST_HOLD;
            warm_cnt <= WARM_ZERO;
            cause    <= CAUSE_RESET;
        end else begin
            state    <= next_state;
            warm_cnt <= next_warm_cnt;
            cause    <= next_cause;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, registered from the next state.
    // ----------------------------------------------------------------
    logic next_sys_reset_n;
    logic next_reg_init;
    logic next_osc_enable;
    logic next_core_clk_en;
    logic next_pc_start;

    // Core runs only in the final state; registers load in the init step.
    always_comb begin
        next_sys_reset_n = (next_state == ST_RUN);                  // see RULE_10
        next_reg_init    = (next_state == ST_INIT);                 // see RULE_10
        next_osc_enable  = (next_state == ST_WARM) || (next_state == ST_RUN);
        next_core_clk_en = (next_state == ST_RUN);                  // see RULE_04
        next_pc_start    = (next_state == ST_RUN) && (state != ST_RUN);
    end

    // Output flip-flops.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            sys_reset_n_o         <= 1'b0;
            reg_init_o            <= 1'b0;
            osc_enable_o          <= 1'b0;
            core_clk_en_o         <= 1'b0;
            pc_start_o            <= 1'b0;
            reset_cause_hi_flag_o <= CAUSE_RESET[1];
            reset_cause_lo_flag_o <= CAUSE_RESET[0];
        end else begin
            sys_reset_n_o         <= next_sys_reset_n;
            reg_init_o            <= next_reg_init;
            osc_enable_o          <= next_osc_enable;
            core_clk_en_o         <= next_core_clk_en;
            pc_start_o            <= next_pc_start;
            reset_cause_hi_flag_o <= next_cause[1];                 // see RULE_09
            reset_cause_lo_flag_o <= next_cause[0];
        end
    end

endmodule : rsq_sequencer
`default_nettype wire

/* rsq_pkg.sv */
// Overview of operation
// RULE_01: Reset pin is active low; high runs.
// RULE_02: Pin low resets at power-up and running.
// RULE_03: Stay in reset until pin is high.
// RULE_04: Release, initialise, warm up, run from zero.
// RULE_05: Low-voltage detector trip resets the system.
// RULE_06: Watchdog overflow resets, then normal operation resumes.
// RULE_07: Hold reset until power-good returns.
// RULE_08: Supply-drop pin low reruns whole sequence.
// RULE_09: Two cause flags: 00 wdt, 10 power, 11 pin.
// RULE_10: Any reset stops core, initialises, clears counter.
// RULE_11: Reset pin passes a flip-flop synchroniser chain.
package rsq_pkg;

    // ----------------------------------------------------------------
    // Timing.
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 100;
    localparam int WARMUP_TIME_NS = 204800;
    // Least time, so the cycle count rounds up.
    localparam int WARMUP_CYCLES  = (WARMUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WARM_CNT_W     = 12;
    localparam logic [WARM_CNT_W-1:0] WARM_LAST = WARM_CNT_W'(WARMUP_CYCLES - 1);
    localparam logic [WARM_CNT_W-1:0] WARM_ZERO = 12'h000;

    // ----------------------------------------------------------------
    // Reset cause codes, high flag first.
    // ----------------------------------------------------------------
    localparam logic [1:0] CAUSE_WDT   = 2'h0;
    localparam logic [1:0] CAUSE_POWER = 2'h2;
    localparam logic [1:0] CAUSE_PIN   = 2'h3;
    localparam logic [1:0] CAUSE_RESET = CAUSE_POWER;

    // ----------------------------------------------------------------
    // Synchroniser reset values: pin released, supply good.
    // ----------------------------------------------------------------
    localparam logic [2:0] SYNC_RESET_VAL = 3'h5;
    // Cycles after reset before the filtered levels are trusted.
    localparam logic [2:0] SETTLE_LAST    = 3'h5;
    localparam logic [2:0] SETTLE_ZERO    = 3'h0;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_HOLD,
        ST_INIT,
        ST_WARM,
        ST_RUN
    } rsq_state_t;

    // Picks the cause code of a reset event; the pin outranks the supply.
    function automatic logic [1:0] rsq_pick_cause(input logic pin_low,
                                                  input logic power_bad,
                                                  input logic old_cause);
        logic [1:0] code;
        code = CAUSE_WDT;
        if (pin_low) begin
            code = CAUSE_PIN;
        end else if (power_bad) begin
            code = CAUSE_POWER;
        end
        return code;
    endfunction : rsq_pick_cause

endpackage : rsq_pkg

/* rsq_sync_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Filtered levels handed from the input synchroniser to the sequencer.
interface rsq_sync_if;
    logic pin_high;
    logic lvd_trip;
    logic power_good;

    modport src (output pin_high, output lvd_trip, output power_good);
    modport dst (input pin_high, input lvd_trip, input power_good);
endinterface : rsq_sync_if
`default_nettype wire

/* rsq_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module rsq_sync
    import rsq_pkg::*;
(
    input  wire logic   core_clk_i,
    input  wire logic   resetn_i,
    input  wire logic   ext_reset_n_i,
    input  wire logic   low_voltage_detector_i,
    input  wire logic   power_good_i,
    rsq_sync_if.src     sync
);

    // ----------------------------------------------------------------
    // Three-stage chains.
    // ----------------------------------------------------------------
    logic [2:0] stage1;
    logic [2:0] stage2;
    logic [2:0] stage3;
    logic [2:0] level;
    logic [2:0] next_level;

    // A change is accepted only once stages two and three agree.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
        end
    end

    // Stage one feeds stage two only.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            stage1 <= SYNC_RESET_VAL;
            stage2 <= SYNC_RESET_VAL;
            stage3 <= SYNC_RESET_VAL;
            level  <= SYNC_RESET_VAL;
        end else begin
            stage1 <= {power_good_i, low_voltage_detector_i, ext_reset_n_i}; // see RULE_11
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
        end
    end

    // Bit 0 is the pin, bit 1 the detector trip, bit 2 power-good.
    assign sync.pin_high   = level[0]; // see RULE_01
    assign sync.lvd_trip   = level[1];
    assign sync.power_good = level[2];

endmodule : rsq_sync
`default_nettype wire

/* rsq_props.sv */
`timescale 1ns/10ps
`default_nettype none
module rsq_props
    import rsq_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic ext_reset_n_i,
    input wire logic low_voltage_detector_i,
    input wire logic power_good_i,
    input wire logic wdt_overflow_i,
    input wire logic sys_reset_n_o,
    input wire logic reg_init_o,
    input wire logic osc_enable_o,
    input wire logic core_clk_en_o,
    input wire logic pc_start_o,
    input wire logic reset_cause_hi_flag_o,
    input wire logic reset_cause_lo_flag_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    wire logic [1:0] cause = {reset_cause_hi_flag_o, reset_cause_lo_flag_o};
    int warm_cnt;
    int next_warm_cnt;
    // Counts cycles spent warming up while the core is still held.
    always_comb begin
        next_warm_cnt = (osc_enable_o && !sys_reset_n_o) ? warm_cnt + 1 : 0;
    end
    // Registers the warm-up count.
    always_ff @(posedge core_clk_i) begin
        warm_cnt <= next_warm_cnt;
    end
    sequence s_init_warm;
        reg_init_o ##1 (osc_enable_o && !sys_reset_n_o && !reg_init_o);
    endsequence
    sequence s_start;
        pc_start_o && core_clk_en_o && osc_enable_o ##1 !pc_start_o;
    endsequence
    chk_init_then_warm: assert property (reg_init_o |-> s_init_warm)
        else $error("warm-up does not follow initialise");
    chk_warm_length: assert property ($rose(sys_reset_n_o) |-> warm_cnt == WARMUP_CYCLES)
        else $error("warm-up length wrong");
    chk_start_pulse: assert property ($rose(sys_reset_n_o) |-> s_start)
        else $error("fetch start pulse wrong");
    chk_clk_in_run: assert property (core_clk_en_o == sys_reset_n_o)
        else $error("core clock gated wrongly");
    chk_wdt_reset: assert property (sys_reset_n_o && wdt_overflow_i && ext_reset_n_i
        && power_good_i && !low_voltage_detector_i |=> !sys_reset_n_o && cause == CAUSE_WDT)
        else $error("watchdog reset missing");
    chk_pin_hold: assert property ((!ext_reset_n_i) [*7] |->
        !sys_reset_n_o && !reg_init_o && cause == CAUSE_PIN)
        else $error("pin low does not hold reset");
    chk_lvd_hold: assert property ((low_voltage_detector_i && ext_reset_n_i) [*7] |->
        !sys_reset_n_o && !osc_enable_o && cause == CAUSE_POWER)
        else $error("detector trip does not hold reset");
    chk_pgood_hold: assert property ((!power_good_i && ext_reset_n_i) [*7] |->
        !sys_reset_n_o && !reg_init_o && cause == CAUSE_POWER)
        else $error("power-bad does not hold reset");
endmodule : rsq_props
bind rsq_sequencer rsq_props u_props (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .ext_reset_n_i(ext_reset_n_i), .low_voltage_detector_i(low_voltage_detector_i),
    .power_good_i(power_good_i), .wdt_overflow_i(wdt_overflow_i),
    .sys_reset_n_o(sys_reset_n_o), .reg_init_o(reg_init_o), .osc_enable_o(osc_enable_o),
    .core_clk_en_o(core_clk_en_o), .pc_start_o(pc_start_o),
    .reset_cause_hi_flag_o(reset_cause_hi_flag_o),
    .reset_cause_lo_flag_o(reset_cause_lo_flag_o));
`default_nettype wire

/* rsq_board_model.sv */
`timescale 1ns/10ps
`default_nettype none
module rsq_board_model (
    input  wire logic       core_clk_i,
    input  wire logic       go_i,
    input  wire logic [7:0] hold_i,
    output var  logic       ext_reset_n_o
);
    logic [7:0] cnt;
    // Pin rests high and is pulled low for hold_i cycles on request.
    initial begin
        ext_reset_n_o = 1'b1;
        cnt = 8'h00;
    end
    // Drives the pin low on a request and releases it high afterwards.
    always @(posedge core_clk_i) begin
        if (go_i) begin
            cnt <= hold_i;
            ext_reset_n_o <= 1'b0;
        end else if (cnt > 8'h01) begin
            cnt <= cnt - 8'h01;
        end else begin
            ext_reset_n_o <= 1'b1;
        end
    end
endmodule : rsq_board_model
`default_nettype wire

/* system_reset_sequencer_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module system_reset_sequencer_tb_top
    import rsq_pkg::*;
;
    logic        core_clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        low_voltage_detector = 1'b0;
    logic        pgood = 1'b1;
    logic        wdt = 1'b0;
    logic        go = 1'b0;
    logic [7:0]  hold = 8'h00;
    logic [31:0] rnd = 32'h11a5f678;
    wire logic   pin_n, rst_n, init, osc, clk_en, start, hi, lo;
    logic [13:0] exp_q[$];
    int          lat, err_count, total_checks, i;
    rsq_board_model board (.core_clk_i(core_clk_i), .go_i(go), .hold_i(hold),
        .ext_reset_n_o(pin_n));
    rsq_sequencer uut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .ext_reset_n_i(pin_n),
        .low_voltage_detector_i(low_voltage_detector), .power_good_i(pgood), .wdt_overflow_i(wdt),
        .sys_reset_n_o(rst_n), .reg_init_o(init), .osc_enable_o(osc),
        .core_clk_en_o(clk_en), .pc_start_o(start), .reset_cause_hi_flag_o(hi),
        .reset_cause_lo_flag_o(lo));
    // Free-running core clock.
    always #50 core_clk_i = ~core_clk_i;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs
    task automatic check(input logic [13:0] seen, input logic [13:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim;
        if (err_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : cyc
    // Notes the cause expected at the next start and waits for that start.
    task automatic run_to(input logic [1:0] c);
        exp_q.push_back({c, 12'(WARMUP_CYCLES)});
        for (i = 0; i < 3000 && start !== 1'b1; i++) @(negedge core_clk_i);
        if (start !== 1'b1) err_count++;
        cyc(2);
    endtask : run_to
    task automatic kick;
        wdt <= 1'b1;
        cyc(1);
        wdt <= 1'b0;
    endtask : kick
    task automatic press(input int extra);
        rnd = xs(rnd);
        hold <= {2'h0, rnd[5:0]} + 8'h08 + 8'(extra);
        go <= 1'b1;
        cyc(1);
        go <= 1'b0;
    endtask : press
    // Compares cause and warm-up length whenever a fetch start appears.
    always @(posedge core_clk_i) begin
        lat <= (init === 1'b1) ? 0 : lat + 1;
        if (start === 1'b1) begin
            if (exp_q.size() == 0) err_count++;
            else check({hi, lo, 12'(lat)}, exp_q.pop_front());
        end
    end
    // Cuts a hang short.
    initial begin
        #5000000;
        err_count++;
        end_sim();
    end
    // Main sequence of scenarios.
    initial begin
        cyc(2);
        resetn_i <= 1'b1;
        run_to(CAUSE_POWER);
        kick();
        run_to(CAUSE_WDT);
        repeat (3) begin
            press(0);
            cyc(6);
            kick();
            run_to(CAUSE_PIN);
        end
        low_voltage_detector <= 1'b1;
        cyc(20);
        low_voltage_detector <= 1'b0;
        run_to(CAUSE_POWER);
        pgood <= 1'b0;
        cyc(20);
        kick();
        pgood <= 1'b1;
        run_to(CAUSE_POWER);
        press(0);
        cyc(110);
        kick();
        run_to(CAUSE_WDT);
        press(20);
        resetn_i <= 1'b0;
        cyc(2);
        resetn_i <= 1'b1;
        run_to(CAUSE_PIN);
        end_sim();
    end
endmodule : system_reset_sequencer_tb_top
`default_nettype wire
